// *** ebcp_cfg.svh ***
// Purpose: Constants of the external bus cycle phaser.
// Assumes: Included by the package and the phaser module.
// Notes:   Field positions refer to chip_select_timing_config_type.
//
// Function
// - Each access runs address setup, command delay, setup, access, hold.
// - Phase lengths come from per chip select config; command delay 0 to 3.
// - Address setup 1 or 2 periods, plus 0 to 3 on window change.
// - Write setup or multiplexed turnaround phase lasts 0 or 1 period.
// - Access phase lasts 1 to 32 periods, optionally stretched by ready.
// - Closing address and write data hold phase lasts 0 to 3 periods.
// - Reference clock output is the system clock with its driver enabled.
// - Read data captured on the edge that ends read strobe.
// - Ready sampled inactive inserts a wait; sampled active ends the access phase.
// - Asynchronous ready adds a synchronization stage, costing a wait state.
// - Ready input polarity is selectable by configuration.
`ifndef EBCP_CFG_SVH
`define EBCP_CFG_SVH

`define EBCP_ADDR_W        24
`define EBCP_DATA_W        16
`define EBCP_CS_W          3
`define EBCP_NUM_CS        8
`define EBCP_CNT_W         6
`define EBCP_RDY_WAIT_MAX  6'h20
`define EBCP_CORE_CLK_NS   50
`define EBCP_DATA_RST      16'h0000
`define EBCP_ADDR_RST      24'h00_0000

`endif

// *** ebcp_pkg.sv ***
// Purpose: Types of the external bus cycle phaser.
// Assumes: ebcp_cfg.svh holds the widths.
// Notes:   None.
`include "ebcp_cfg.svh"

package ebcp_pkg;

    typedef enum logic [2:0] {
        PH_IDLE  = 3'b000,
        PH_SETUP = 3'b001,
        PH_CMD   = 3'b010,
        PH_WSET  = 3'b011,
        PH_ACC   = 3'b100,
        PH_HOLD  = 3'b101
    } phase_type;

    // Per chip select timing; access holds periods minus one.
    typedef struct packed {
        logic       ready_pol;
        logic       ready_async;
        logic       ready_en;
        logic [1:0] hold;
        logic [4:0] access;
        logic       wsetup;
        logic [1:0] cmd_delay;
        logic [1:0] win_extra;
        logic       setup_long;
    } chip_select_timing_config_type;

    typedef struct packed {
        logic                    write;
        logic [`EBCP_CS_W-1:0]   cs;
        logic [`EBCP_ADDR_W-1:0] addr;
        logic [`EBCP_DATA_W-1:0] wdata;
    } bus_request_type;

endpackage : ebcp_pkg

// *** ebcp_props.sv ***
// Purpose: Concurrent checks on the ports of the bus cycle phaser.
// Assumes: Phase codes follow phase_type.
// Notes:   Bound to every instance of the phaser.
`timescale 1ns/1ps
`default_nettype none

module ebcp_props (
    input wire logic       core_clk,
    input wire logic       rst_b,
    input wire logic       clk_out_en,
    input wire logic       req_ready,
    input wire logic [2:0] phase,
    input wire logic       bus_reference_clock,
    input wire logic       clk_drv_en,
    input wire logic       ale,
    input wire logic       rd_b,
    input wire logic       wr_b
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);

    // ----------
    // Phase and port checks
    // ----------
    a_setup_first: assert property (
        (phase == 3'd0 ##1 phase != 3'd0) |-> phase == 3'd1)
        else $error("cycle did not open with address setup");
    a_phase_order: assert property (
        phase != 3'd0 |=> phase == 3'd0 || phase >= $past(phase))
        else $error("phase went backwards");
    a_setup_bound: assert property (
        phase == 3'd1 [*5] |=> phase != 3'd1)
        else $error("address setup longer than five periods");
    a_cmd_bound: assert property (
        phase == 3'd2 [*3] |=> phase != 3'd2)
        else $error("command delay longer than three periods");
    a_wset_bound: assert property (
        phase == 3'd3 |=> phase != 3'd3)
        else $error("write setup longer than one period");
    a_hold_bound: assert property (
        phase == 3'd5 [*3] |=> phase != 3'd5)
        else $error("hold longer than three periods");
    a_write_strobe: assert property (
        !wr_b |-> phase == 3'd4)
        else $error("write strobe outside access");
    a_ale_setup: assert property (
        ale == (phase == 3'd1))
        else $error("address latch enable outside setup");
    a_read_strobe: assert property (
        !rd_b |-> phase == 3'd3 || phase == 3'd4)
        else $error("read strobe outside access");
    a_idle_accept: assert property (
        req_ready == (phase == 3'd0))
        else $error("request ready not tied to idle");
    a_ref_clock: assert property (@(negedge core_clk) disable iff (!rst_b)
        bus_reference_clock == clk_out_en && clk_drv_en == clk_out_en)
        else $error("reference clock output wrong");
endmodule : ebcp_props

bind external_bus_cycle_phaser ebcp_props u_props (
    .core_clk(core_clk), .rst_b(rst_b), .clk_out_en(clk_out_en),
    .req_ready(req_ready), .phase(phase), .wr_b(wr_b),
    .ale(ale), .rd_b(rd_b),
    .bus_reference_clock(bus_reference_clock), .clk_drv_en(clk_drv_en));

`default_nettype wire

// *** ext_mem_model.sv ***
// Purpose: External memory with a ready handshake on the parallel bus.
// Assumes: link_clk runs freely; any low chip select selects it.
// Notes:   Read data is the address xor 16'h5A5A.
`timescale 1ns/1ps
`default_nettype none

module ext_mem_model (
    input  wire logic        link_clk,
    input  wire logic [7:0]  cs_b,
    input  wire logic        wr_b,
    input  wire logic [23:0] addr_o,
    input  wire logic [15:0] data_o,
    input  wire logic        data_oe,
    input  wire logic        rdy_pol,
    input  wire logic [7:0]  rdy_dly,
    output logic      [15:0] data_i = 16'h0000,
    output logic             ready_pin = 1'b0,
    output logic      [15:0] wr_seen = 16'h0000
);
    logic [7:0] wait_q = 8'h00;
    wire logic sel = cs_b != 8'hFF;

    // ----------
    // Bus response
    // ----------
    always @(posedge link_clk) begin
        if (sel && !data_oe) data_i <= addr_o[15:0] ^ 16'h5A5A;
        else data_i <= ~data_i;
        if (!sel) wait_q <= 8'h00;
        else if (wait_q != 8'hFF) wait_q <= wait_q + 8'h01;
        ready_pin <= (sel && wait_q >= rdy_dly) ? rdy_pol : !rdy_pol;
        if (!wr_b && data_oe) wr_seen <= data_o;
    end
endmodule : ext_mem_model

`default_nettype wire

// *** external_bus_cycle_phaser.sv ***
// Purpose: Sequences external bus accesses in five programmable phases.
// Assumes: One access at a time; config is stable while a cycle runs.
// Notes:   Pins other than the reference clock and its driver enable are registered and follow the next phase.
`timescale 1ns/1ps
`default_nettype none

`include "ebcp_cfg.svh"

module external_bus_cycle_phaser
    import ebcp_pkg::*;
#(
    parameter int NUM_CS = `EBCP_NUM_CS
) (
    input  wire logic                          core_clk,
    input  wire logic                          rst_b,
    input  wire logic                          link_clk,
    input  wire chip_select_timing_config_type chip_select_timing_config [NUM_CS],
    input  wire logic                          mux_mode,
    input  wire logic                          clk_out_en,
    input  wire logic                          req_valid,
    output logic                               req_ready,
    input  wire bus_request_type               req,
    output logic                               done,
    output logic [`EBCP_DATA_W-1:0]            rdata,
    output logic [2:0]                         phase,
    output logic                               bus_reference_clock,
    output logic                               clk_drv_en,
    output logic [`EBCP_ADDR_W-1:0]            addr_o,
    output logic                               ale,
    output logic [NUM_CS-1:0]                  cs_b,
    output logic                               rd_b,
    output logic                               wr_b,
    output logic                               high_byte_strobe_b,
    output logic [`EBCP_DATA_W-1:0]            data_o,
    output logic                               data_oe,
    input  wire logic [`EBCP_DATA_W-1:0]       data_i,
    input  wire logic                          ready_pin
);

    phase_type                     state_q;
    phase_type                     state_d;
    logic [`EBCP_CNT_W-1:0]        cnt_q;
    chip_select_timing_config_type cfg_q;
    bus_request_type               req_q;
    logic                          win_chg_q;
    logic                          win_valid_q;
    logic [`EBCP_CS_W-1:0]         last_win_q;
    logic                          ready_link;
    logic                          rdy_s1_q;
    logic                          rdy_s2_q;
    logic                          rdy_s3_q;
    logic                          rdy_active;
    logic [`EBCP_DATA_W-1:0]       din_s1_q;
    logic [`EBCP_DATA_W-1:0]       din_s2_q;
    logic [`EBCP_DATA_W-1:0]       rdata_q;
    logic                          done_q;
    logic [`EBCP_CNT_W-1:0]        setup_len;
    logic                          phase_end;
    logic                          acc_end;
    logic                          rd_now;
    logic                          wr_now;
    logic [`EBCP_CS_W-1:0]         cs_sel;

    // ------------------------------------------------------------
    // Ready path across the link clock domain.
    // ------------------------------------------------------------
    ready_link_sampler u_ready (
        .link_clk   (link_clk),
        .rst_b      (rst_b),
        .ready_pin  (ready_pin),
        .ready_link (ready_link)
    );

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdy_s1_q <= 1'b0;
            rdy_s2_q <= 1'b0;
            rdy_s3_q <= 1'b0;
        end else begin
            rdy_s1_q <= ready_link;
            rdy_s2_q <= rdy_s1_q;
            rdy_s3_q <= rdy_s2_q;
        end
    end

    // Polarity compare after the synchronizer; async mode reads one more
    // stage.
    assign rdy_active = ((cfg_q.ready_async ? rdy_s3_q : rdy_s2_q)
                         == cfg_q.ready_pol);

    // ------------------------------------------------------------
    // Read data synchronizer.
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            din_s1_q <= `EBCP_DATA_RST;
            din_s2_q <= `EBCP_DATA_RST;
        end else begin
            din_s1_q <= data_i;
            din_s2_q <= din_s1_q;
        end
    end

    // ------------------------------------------------------------
    // Phase lengths and end conditions.
    // ------------------------------------------------------------
    assign setup_len = {5'b0_0000, 1'b1} + {5'b0_0000, cfg_q.setup_long}
                     + (win_chg_q ? {4'b0000, cfg_q.win_extra}
                                  : {`EBCP_CNT_W{1'b0}});

    assign acc_end = (cnt_q >= {1'b0, cfg_q.access})
                   && (!cfg_q.ready_en || rdy_active);

    always_comb begin
        phase_end = 1'b0;
        unique case (state_q)
            PH_IDLE:  phase_end = 1'b0;
            PH_SETUP: phase_end = (cnt_q == setup_len - 6'h01);
            PH_CMD:   phase_end = (cnt_q == {4'b0000, cfg_q.cmd_delay}
                                            - 6'h01);
            PH_WSET:  phase_end = 1'b1;
            PH_ACC:   phase_end = acc_end;
            PH_HOLD:  phase_end = (cnt_q == {4'b0000, cfg_q.hold}
                                            - 6'h01);
            default:  phase_end = 1'b1;
        endcase
    end

    // ------------------------------------------------------------
    // Phase sequencer; zero length phases are skipped.
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            PH_IDLE: begin
                if (req_valid) begin
                    state_d = PH_SETUP;
                end
            end
            PH_SETUP: begin
                if (phase_end) begin
                    if (cfg_q.cmd_delay != 2'b00) begin
                        state_d = PH_CMD;
                    end else if (cfg_q.wsetup) begin
                        state_d = PH_WSET;
                    end else begin
                        state_d = PH_ACC;
                    end
                end
            end
            PH_CMD: begin
                if (phase_end) begin
                    state_d = cfg_q.wsetup ? PH_WSET : PH_ACC;
                end
            end
            PH_WSET: begin
                state_d = PH_ACC;
            end
            PH_ACC: begin
                if (phase_end) begin
                    state_d = (cfg_q.hold != 2'b00) ? PH_HOLD : PH_IDLE;
                end
            end
            PH_HOLD: begin
                if (phase_end) begin
                    state_d = PH_IDLE;
                end
            end
            default: state_d = PH_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= PH_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Phase counter; it saturates while ready holds the access phase.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q <= {`EBCP_CNT_W{1'b0}};
        end else if (state_d != state_q) begin
            cnt_q <= {`EBCP_CNT_W{1'b0}};
        end else if (state_q != PH_IDLE && cnt_q != `EBCP_RDY_WAIT_MAX) begin
            cnt_q <= cnt_q + 6'h01;
        end
    end

    // ------------------------------------------------------------
    // Request capture and address window tracking.
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_q       <= '0;
            req_q       <= '0;
            win_chg_q   <= 1'b0;
            win_valid_q <= 1'b0;
            last_win_q  <= {`EBCP_CS_W{1'b0}};
        end else if (state_q == PH_IDLE && req_valid) begin
            cfg_q       <= chip_select_timing_config[req.cs];
            req_q       <= req;
            win_chg_q   <= !win_valid_q || (last_win_q != req.cs);
            win_valid_q <= 1'b1;
            last_win_q  <= req.cs;
        end
    end

    // ------------------------------------------------------------
    // Read capture and completion.
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_q <= `EBCP_DATA_RST;
            done_q  <= 1'b0;
        end else begin
            done_q <= (state_q != PH_IDLE) && (state_d == PH_IDLE);
            if (state_q == PH_ACC && phase_end && !req_q.write) begin
                rdata_q <= din_s2_q;
            end
        end
    end

    // ------------------------------------------------------------
    // Bus pins, registered from the next phase.
    // ------------------------------------------------------------
    assign rd_now = !req_q.write
                 && (state_d == PH_WSET || state_d == PH_ACC);
    assign wr_now = req_q.write && state_d == PH_ACC;

    // A new request selects its own chip, as its copy lands on this edge.
    assign cs_sel = (state_q == PH_IDLE) ? req.cs : req_q.cs;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            addr_o             <= `EBCP_ADDR_RST;
            ale                <= 1'b0;
            cs_b               <= {NUM_CS{1'b1}};
            rd_b               <= 1'b1;
            wr_b               <= 1'b1;
            high_byte_strobe_b <= 1'b1;
            data_o             <= `EBCP_DATA_RST;
            data_oe            <= 1'b0;
        end else begin
            if (state_q == PH_IDLE && req_valid) begin
                addr_o <= req.addr;
            end
            ale  <= (state_d == PH_SETUP);
            cs_b <= {NUM_CS{1'b1}};
            if (state_d != PH_IDLE) begin
                cs_b[cs_sel] <= 1'b0;
            end
            high_byte_strobe_b <= (state_d == PH_IDLE);
            rd_b               <= !rd_now;
            wr_b               <= !wr_now;
            if (mux_mode && state_d == PH_SETUP) begin
                data_o  <= state_q == PH_IDLE ? req.addr[`EBCP_DATA_W-1:0]
                                              : data_o;
                data_oe <= 1'b1;
            end else begin
                data_o  <= req_q.wdata;
                data_oe <= req_q.write && state_d != PH_IDLE
                        && (state_d != PH_SETUP || mux_mode)
                        && !(mux_mode && state_d == PH_WSET);
            end
        end
    end

    // ------------------------------------------------------------
    // Reference clock and user side outputs.
    // ------------------------------------------------------------
    assign bus_reference_clock = core_clk & clk_out_en;
    assign clk_drv_en          = clk_out_en;
    assign req_ready           = (state_q == PH_IDLE);
    assign done                = done_q;
    assign rdata               = rdata_q;
    assign phase               = state_q;

endmodule : external_bus_cycle_phaser

`default_nettype wire

// *** ready_link_sampler.sv ***
// Purpose: Samples the ready pin on the external module's clock.
// Assumes: link_clk is free running while ready is in use.
// Notes:   Output is a level; the core side synchronizes it again.
`timescale 1ns/1ps
`default_nettype none

module ready_link_sampler (
    input  wire logic link_clk,
    input  wire logic rst_b,
    input  wire logic ready_pin,
    output logic      ready_link
);

    logic meta_q;
    logic level_q;

    // ------------------------------------------------------------
    // Two stage sampler in the link domain.
    // ------------------------------------------------------------
    always_ff @(posedge link_clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_q  <= 1'b0;
            level_q <= 1'b0;
        end else begin
            meta_q  <= ready_pin;
            level_q <= meta_q;
        end
    end

    assign ready_link = level_q;

endmodule : ready_link_sampler

`default_nettype wire

// *** tb_top.sv ***
// Purpose: Self-checking bench of the bus cycle phaser.
// Assumes: Package, checker and memory model are compiled first.
// Notes:   The driver queues notes; the monitor checks them at done.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin failures++; \
    $display("MISMATCH %0t value differs", $time); end end

module tb_top
    import ebcp_pkg::*;
;
    typedef struct {int len; int cs; bit ex; bit rd; bit wr;
                    logic [15:0] v;} note_type;
    note_type notes [$];
    int failures = 0, n_tests = 0, seed = 54, last_cs = -1, cnt = 0;
    logic core_clk = 0, link_clk = 0, rst_b = 0, req_valid = 0, rdy_n = 0;
    logic mux_mode = 0, clk_out_en = 0, rdy_pol = 0;
    logic [7:0] rdy_dly = 8'h3C;
    chip_select_timing_config_type cfg [8];
    bus_request_type req = '0;
    wire logic req_ready, done, wr_b, data_oe, ready_pin;
    wire logic [2:0] phase;
    wire logic [7:0] cs_b;
    wire logic [23:0] addr_o;
    wire logic [15:0] rdata, data_o, data_i, wr_seen;

    external_bus_cycle_phaser uut (
        .core_clk(core_clk), .rst_b(rst_b), .link_clk(link_clk),
        .chip_select_timing_config(cfg), .mux_mode(mux_mode),
        .clk_out_en(clk_out_en), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .done(done), .rdata(rdata), .phase(phase),
        .bus_reference_clock(), .clk_drv_en(), .addr_o(addr_o), .ale(),
        .cs_b(cs_b), .rd_b(), .wr_b(wr_b), .high_byte_strobe_b(),
        .data_o(data_o), .data_oe(data_oe), .data_i(data_i),
        .ready_pin(ready_pin));
    ext_mem_model mem (
        .link_clk(link_clk), .cs_b(cs_b), .wr_b(wr_b), .addr_o(addr_o),
        .data_o(data_o), .data_oe(data_oe), .rdy_pol(rdy_pol),
        .rdy_dly(rdy_dly), .data_i(data_i), .ready_pin(ready_pin),
        .wr_seen(wr_seen));

    // ----------
    // Clocks, tasks and monitor
    // ----------
    initial forever #25 core_clk = ~core_clk;
    initial begin
        #1.7;
        forever #3 link_clk = ~link_clk;
    end

    task automatic report_and_stop;
        if (failures == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop

    task automatic send(input logic w, input int cs,
                        input chip_select_timing_config_type c, input int mn);
        note_type nt;
        bus_request_type r;
        int i;
        r.write = w;
        r.cs = 3'(cs);
        r.addr = 24'($random(seed));
        r.wdata = 16'($random(seed));
        nt.len = 2 + c.setup_long + c.cmd_delay + c.wsetup + c.access
                 + c.hold + ((cs != last_cs) ? c.win_extra : 0);
        nt.ex = (mn == 0);
        if (mn > 0) nt.len = mn;
        nt.rd = !w && c.access >= 5'h03;
        nt.wr = w;
        nt.cs = cs;
        nt.v = w ? r.wdata : r.addr[15:0] ^ 16'h5A5A;
        notes.push_back(nt);
        last_cs = cs;
        cfg[cs] <= c;
        req <= r;
        req_valid <= 1'b1;
        for (i = 0; i < 400; i++) begin
            @(posedge core_clk);
            if (rdy_n) break;
        end
        if (i == 400) begin
            failures++;
            report_and_stop();
        end
    endtask : send

    task automatic drain;
        int i;
        for (i = 0; i < 400 && notes.size() > 0; i++) @(posedge core_clk);
        if (i == 400) begin
            failures++;
            report_and_stop();
        end
    endtask : drain

    always @(negedge core_clk) begin : mon
        note_type nt;
        rdy_n <= req_ready;
        if (rst_b && phase != 3'd0 && notes.size() > 0)
            `CHK(cs_b, ~(8'h01 << notes[0].cs))
        if (!rst_b) cnt = 0;
        else if (done) begin
            `CHK(notes.size() > 0, 1'b1)
            if (notes.size() > 0) begin
                nt = notes.pop_front();
                if (nt.ex) `CHK(cnt, nt.len)
                else `CHK(cnt >= nt.len, 1'b1)
                if (nt.rd) `CHK(rdata, nt.v)
                if (nt.wr) `CHK(wr_seen, nt.v)
            end
            cnt = int'(phase != 3'd0);
        end else if (phase != 3'd0) cnt++;
    end

    // ----------
    // Scenarios
    // ----------
    initial begin
        for (int k = 0; k < 8; k++) cfg[k] = '0;
        repeat (3) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        send(1'b1, 5, 16'h1FFF, 0);
        send(1'b0, 5, 16'h1FFF, 0);
        for (int m = 0; m < 2; m++) begin
            mux_mode <= m[0];
            clk_out_en <= !m[0];
            for (int k = 0; k < 8; k++)
                send(1'($random(seed)), {$random(seed)} % 3,
                     16'($random(seed)) & 16'h1FFF, 0);
            req_valid <= 1'b0;
            drain();
        end
        for (int p = 0; p < 4; p++) begin
            rdy_pol <= p[1];
            send(p[0], 1 + p, 16'h2000 | 16'(p << 14), 8);
            req_valid <= 1'b0;
            drain();
            repeat (10) @(posedge core_clk);
        end
        send(1'b1, 6, 16'h07C0, 0);
        repeat (5) @(posedge core_clk);
        rst_b <= 1'b0;
        req_valid <= 1'b0;
        @(negedge core_clk);
        `CHK(cs_b, 8'hFF)
        `CHK(phase, 3'd0)
        notes.delete();
        last_cs = -1;
        repeat (3) @(posedge core_clk);
        rst_b <= 1'b1;
        send(1'b0, 6, 16'h00C5, 0);
        req_valid <= 1'b0;
        drain();
        report_and_stop();
    end
endmodule : tb_top

`default_nettype wire
